// ### verilog/cpu_seq_pkg.sv
package cpu_seq_pkg;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int PCL_W = 8;
    localparam int PC_HIGH_W_SMALL = 4;
    localparam int PC_HIGH_W_LARGE = 5;
    localparam int INSTR_W = 16;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 8;
    localparam int PHASE_COUNT = 4;
    localparam int ADDR_FIELD_W = 13;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    localparam logic GIE_RESET = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [3:0] {
        PH_T1 = 4'b0001,
        PH_T2 = 4'b0010,
        PH_T3 = 4'b0100,
        PH_T4 = 4'b1000
    } four_clock_phases_t;

    typedef enum logic [2:0] {
        OPC_NOP = 3'h0,
        OPC_ALU_ACC = 3'h1,
        OPC_ALU_PCL = 3'h2,
        OPC_JUMP = 3'h3,
        OPC_CALL = 3'h4,
        OPC_RETURN = 3'h5,
        OPC_INT_RETURN = 3'h6,
        OPC_SKIP_ZERO = 3'h7
    } opcode_t;

    typedef enum logic [3:0] {
        ALU_LOAD = 4'h0,
        ALU_ADD = 4'h1,
        ALU_ADC = 4'h2,
        ALU_SUB = 4'h3,
        ALU_SBC = 4'h4,
        ALU_AND = 4'h5,
        ALU_OR = 4'h6,
        ALU_XOR = 4'h7,
        ALU_CPL = 4'h8,
        ALU_RR = 4'h9,
        ALU_RRC = 4'ha,
        ALU_RL = 4'hb,
        ALU_RLC = 4'hc,
        ALU_INC = 4'hd,
        ALU_DEC = 4'he
    } alu_op_t;

    typedef struct packed {
        opcode_t opc;
        logic src_pcl;
        alu_op_t aluop;
        logic [7:0] imm;
    } instr_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } status_t;

    typedef struct packed {
        logic [7:0] data;
        status_t status;
    } alu_result_t;

    localparam status_t STATUS_RESET = 4'h0;

endpackage : cpu_seq_pkg

// ### verilog/return_stack_mem.sv
`timescale 1ns/1ps
module return_stack_mem #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    // Clock and control
    input logic clk,
    input logic reset,
    input logic ce,
    // Write port
    input logic wr_en,
    input logic [AW-1:0] wr_addr,
    input logic [WIDTH-1:0] wr_data,
    // Registered read port
    input logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_r
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (ce && wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rd_data_r <= '0;
        end
        else if (ce)
        begin
            rd_data_r <= mem[rd_addr];
        end
    end

endmodule : return_stack_mem

// ### verilog/cpu_fetch_sequencer_stack.sv
`timescale 1ns/1ps
module cpu_fetch_sequencer_stack #(
    parameter int PC_HIGH_W = cpu_seq_pkg::PC_HIGH_W_SMALL,
    parameter int STACK_DEPTH = cpu_seq_pkg::STACK_DEPTH,
    parameter logic [12:0] INT_VECTOR = cpu_seq_pkg::INT_VECTOR
) (
    // Clock, reset, enable
    input logic clk,
    input logic reset,
    input logic ce,
    // Program memory
    output logic [cpu_seq_pkg::PCL_W+PC_HIGH_W-1:0] prog_addr,
    input logic [cpu_seq_pkg::INSTR_W-1:0] prog_data,
    // Interrupt logic
    input logic irq_req,
    output logic irq_ack,
    // Core state
    output cpu_seq_pkg::four_clock_phases_t phase,
    output logic dummy_cycle,
    output logic [cpu_seq_pkg::DATA_W-1:0] acc,
    output cpu_seq_pkg::status_t status
);

    localparam int PC_W = cpu_seq_pkg::PCL_W + PC_HIGH_W;
    localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
    localparam int CNT_W = $clog2(STACK_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STACK_DEPTH);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [SP_W-1:0] ptr_inc(input logic [SP_W-1:0] p);
        ptr_inc = (32'(p) == STACK_DEPTH - 1) ? '0 : SP_W'(p + 1'b1);
    endfunction : ptr_inc

    function automatic logic [SP_W-1:0] ptr_dec(input logic [SP_W-1:0] p);
        ptr_dec = (p == '0) ? SP_W'(STACK_DEPTH - 1) : SP_W'(p - 1'b1);
    endfunction : ptr_dec

    function automatic cpu_seq_pkg::alu_result_t alu_calc(
        input cpu_seq_pkg::alu_op_t op,
        input logic [7:0] a,
        input logic [7:0] b,
        input cpu_seq_pkg::status_t st
    );
        cpu_seq_pkg::alu_result_t r;
        logic [8:0] sum;
        logic [4:0] nib;
        logic cin;
        logic [7:0] bb;
        r.data = a;
        r.status = st;
        sum = '0;
        nib = '0;
        cin = 1'b0;
        bb = b;
        case (op)
            cpu_seq_pkg::ALU_LOAD: r.data = b;
            cpu_seq_pkg::ALU_ADD, cpu_seq_pkg::ALU_ADC,
            cpu_seq_pkg::ALU_SUB, cpu_seq_pkg::ALU_SBC:
            begin
                // Subtraction adds the inverse; carry high means no borrow
                if (op == cpu_seq_pkg::ALU_SUB || op == cpu_seq_pkg::ALU_SBC)
                begin
                    bb = ~b;
                end
                case (op)
                    cpu_seq_pkg::ALU_ADC: cin = st.c;
                    cpu_seq_pkg::ALU_SUB: cin = 1'b1;
                    cpu_seq_pkg::ALU_SBC: cin = st.c;
                    default: cin = 1'b0;
                endcase
                sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
                nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
                r.data = sum[7:0];
                r.status.c = sum[8];
                r.status.ac = nib[4];
                r.status.ov = (a[7] == bb[7]) && (sum[7] != a[7]);
            end
            cpu_seq_pkg::ALU_AND: r.data = a & b;
            cpu_seq_pkg::ALU_OR: r.data = a | b;
            cpu_seq_pkg::ALU_XOR: r.data = a ^ b;
            cpu_seq_pkg::ALU_CPL: r.data = ~a;
            cpu_seq_pkg::ALU_RR: r.data = {a[0], a[7:1]};
            cpu_seq_pkg::ALU_RRC:
            begin
                r.data = {st.c, a[7:1]};
                r.status.c = a[0];
            end
            cpu_seq_pkg::ALU_RL: r.data = {a[6:0], a[7]};
            cpu_seq_pkg::ALU_RLC:
            begin
                r.data = {a[6:0], st.c};
                r.status.c = a[7];
            end
            cpu_seq_pkg::ALU_INC: r.data = a + 8'h01;
            cpu_seq_pkg::ALU_DEC: r.data = a - 8'h01;
            default: r.data = a;
        endcase
        // Rotations leave the zero flag alone
        if (op != cpu_seq_pkg::ALU_RR && op != cpu_seq_pkg::ALU_RRC &&
            op != cpu_seq_pkg::ALU_RL && op != cpu_seq_pkg::ALU_RLC)
        begin
            r.status.z = (r.data == 8'h00);
        end
        alu_calc = r;
    endfunction : alu_calc

    // ************************************************************
    // State
    // ************************************************************
    cpu_seq_pkg::four_clock_phases_t phase_r;
    cpu_seq_pkg::instr_t ir_r;
    logic ir_valid_r;
    logic [PC_W-1:0] pc_r;
    logic [7:0] acc_r;
    cpu_seq_pkg::status_t status_r;
    logic gie_r;
    logic irq_pending_r;
    logic irq_ack_r;
    logic [SP_W-1:0] sp_r;
    logic [CNT_W-1:0] depth_r;
    logic [PC_W-1:0] stack_top;

    logic cyc_end;
    logic is_jump;
    logic is_call;
    logic is_return;
    logic is_int_return;
    logic is_pcl_write;
    logic is_alu_acc;
    logic skip_taken;
    logic branch_now;
    logic stack_full;
    logic stack_empty;
    logic take_irq;
    logic push;
    logic pop;
    logic [PC_W-1:0] pc_plus1;
    logic [PC_W-1:0] pc_nxt;
    logic [7:0] alu_b;
    cpu_seq_pkg::alu_result_t alu_res;

    // ************************************************************
    // Decode
    // ************************************************************
    assign cyc_end = ce && (phase_r == cpu_seq_pkg::PH_T4);
    assign is_jump = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_JUMP);
    assign is_call = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_CALL);
    assign is_return = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_RETURN);
    assign is_int_return = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_INT_RETURN);
    assign is_pcl_write = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_ALU_PCL);
    assign is_alu_acc = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_ALU_ACC);
    assign skip_taken = ir_valid_r && (ir_r.opc == cpu_seq_pkg::OPC_SKIP_ZERO) &&
                        (acc_r == 8'h00);
    assign branch_now = is_jump | is_call | is_return | is_int_return | is_pcl_write;

    assign stack_full = (depth_r == CNT_FULL);
    assign stack_empty = (depth_r == '0);
    // Interrupt waits while the stack is full or a branch is in flight
    assign take_irq = irq_pending_r && gie_r && !stack_full && !branch_now &&
                      !skip_taken;
    assign push = cyc_end && (is_call || take_irq);
    assign pop = cyc_end && (is_return || is_int_return);

    // Low byte as operand makes the low counter byte readable
    assign alu_b = ir_r.src_pcl ? pc_r[7:0] : ir_r.imm;
    assign alu_res = alu_calc(ir_r.aluop, acc_r, alu_b, status_r);
    assign pc_plus1 = pc_r + {{(PC_W-1){1'b0}}, 1'b1};

    always_comb
    begin
        pc_nxt = pc_plus1;
        if (take_irq)
        begin
            pc_nxt = INT_VECTOR[PC_W-1:0];
        end
        else if (is_jump || is_call)
        begin
            pc_nxt = ir_r[PC_W-1:0];
        end
        else if (is_return || is_int_return)
        begin
            pc_nxt = stack_top;
        end
        else if (is_pcl_write)
        begin
            pc_nxt = {pc_r[PC_W-1:8], alu_res.data};
        end
    end

    // ************************************************************
    // Phase generator
    // ************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            phase_r <= cpu_seq_pkg::PH_T1;
        end
        else if (ce)
        begin
            case (phase_r)
                cpu_seq_pkg::PH_T1: phase_r <= cpu_seq_pkg::PH_T2;
                cpu_seq_pkg::PH_T2: phase_r <= cpu_seq_pkg::PH_T3;
                cpu_seq_pkg::PH_T3: phase_r <= cpu_seq_pkg::PH_T4;
                cpu_seq_pkg::PH_T4: phase_r <= cpu_seq_pkg::PH_T1;
                default: phase_r <= cpu_seq_pkg::PH_T1;
            endcase
        end
    end

    // ************************************************************
    // Fetch and program counter
    // ************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pc_r <= cpu_seq_pkg::RESET_VECTOR[PC_W-1:0];
            ir_r <= '0;
            ir_valid_r <= 1'b0;
        end
        else if (cyc_end)
        begin
            // Counter and prefetch change at the start of the first phase
            pc_r <= pc_nxt;
            ir_r <= cpu_seq_pkg::instr_t'(prog_data);
            // A redirected flow throws the prefetched word away
            ir_valid_r <= !(branch_now || skip_taken || take_irq);
        end
    end

    // ************************************************************
    // Accumulator and status
    // ************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            acc_r <= 8'h00;
            status_r <= cpu_seq_pkg::STATUS_RESET;
        end
        else if (cyc_end && (is_alu_acc || is_pcl_write))
        begin
            if (is_alu_acc)
            begin
                acc_r <= alu_res.data;
            end
            status_r <= alu_res.status;
        end
    end

    // ************************************************************
    // Interrupt acknowledge
    // ************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            irq_pending_r <= 1'b0;
            gie_r <= cpu_seq_pkg::GIE_RESET;
            irq_ack_r <= 1'b0;
        end
        else if (ce)
        begin
            // A new request wins over the clear from acknowledge
            if (irq_req)
            begin
                irq_pending_r <= 1'b1;
            end
            else if (cyc_end && take_irq)
            begin
                irq_pending_r <= 1'b0;
            end
            if (cyc_end && take_irq)
            begin
                gie_r <= 1'b0;
            end
            else if (cyc_end && is_int_return)
            begin
                gie_r <= 1'b1;
            end
            irq_ack_r <= cyc_end && take_irq;
        end
    end

    // ************************************************************
    // Return stack, hidden from software
    // ************************************************************
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sp_r <= '0;
            depth_r <= '0;
        end
        else if (push)
        begin
            // Full stack wraps over its oldest entry
            sp_r <= ptr_inc(sp_r);
            if (!stack_full)
            begin
                depth_r <= depth_r + 1'b1;
            end
        end
        else if (pop)
        begin
            sp_r <= ptr_dec(sp_r);
            if (!stack_empty)
            begin
                depth_r <= depth_r - 1'b1;
            end
        end
    end

    return_stack_mem #(
        .WIDTH(PC_W),
        .DEPTH(STACK_DEPTH),
        .AW(SP_W)
    ) u_stack (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .wr_en(push),
        .wr_addr(sp_r),
        .wr_data(pc_r),
        .rd_addr(ptr_dec(sp_r)),
        .rd_data_r(stack_top)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prog_addr = pc_r;
    assign irq_ack = irq_ack_r;
    assign phase = phase_r;
    assign dummy_cycle = !ir_valid_r;
    assign acc = acc_r;
    assign status = status_r;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    property p_phase_onehot;
        $onehot(phase_r);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");

    property p_phase_wrap;
        cyc_end |=> phase_r == cpu_seq_pkg::PH_T1 ##1
            phase_r == ($past(ce) ? cpu_seq_pkg::PH_T2 : cpu_seq_pkg::PH_T1);
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase order broken");

    property p_pc_hold;
        !cyc_end |=> $stable(pc_r);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved mid-cycle");

    property p_pc_inc;
        cyc_end && !branch_now && !take_irq |=> pc_r == $past(pc_plus1);
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc did not increment");

    property p_branch_dummy;
        cyc_end && branch_now |=> dummy_cycle && pc_r == $past(pc_nxt);
    endproperty
    a_branch_dummy: assert property (p_branch_dummy) else $error("branch lacks dummy");

    property p_skip_dummy;
        cyc_end && skip_taken |=> dummy_cycle && pc_r == $past(pc_plus1);
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("skip not taken");

    property p_pcl_page;
        cyc_end && is_pcl_write |=> dummy_cycle && pc_r[PC_W-1:8] == $past(pc_r[PC_W-1:8]);
    endproperty
    a_pcl_page: assert property (p_pcl_page) else $error("low byte jump left page");

    property p_irq_withheld;
        cyc_end && stack_full |=> !irq_ack;
    endproperty
    a_irq_withheld: assert property (p_irq_withheld) else $error("ack on full stack");

    property p_return_restore;
        cyc_end && is_return && !stack_empty |=> pc_r == $past(stack_top);
    endproperty
    a_return_restore: assert property (p_return_restore) else $error("return bad pc");

    property p_zero_flag;
        cyc_end && is_alu_acc && ir_r.aluop == cpu_seq_pkg::ALU_LOAD
            |=> status_r.z == (acc_r == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

endmodule : cpu_fetch_sequencer_stack

// ### dv/prog_mem_model.sv
`timescale 1ns/1ps
module prog_mem_model #(
    parameter int AW = 12
) (
    // Clock
    input wire logic clk,
    // Program memory
    input wire logic [AW-1:0] prog_addr,
    output logic [15:0] prog_data,
    // Interrupt logic
    input wire logic irq_fire,
    output logic irq_req
);
    logic [15:0] rom [2**AW];
    logic req_r = 1'b0;

    // Word is presented combinationally for the whole instruction cycle
    assign prog_data = rom[prog_addr];
    assign irq_req = req_r;

    // One clock request pulse per fire
    always @(posedge clk)
    begin
        req_r <= irq_fire;
    end
endmodule : prog_mem_model

// ### dv/tb_cpu_fetch_sequencer_stack.sv
`timescale 1ns/1ps
module tb_cpu_fetch_sequencer_stack;
    localparam int AW = 12;
    localparam int DEPTH = 2;
    localparam int TMO = 20000;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic irq_fire = 1'b0;
    logic irq_req;
    logic irq_ack;
    logic dummy_cycle;
    logic [AW-1:0] prog_addr;
    logic [15:0] prog_data;
    logic [7:0] acc;
    cpu_seq_pkg::four_clock_phases_t phase;
    cpu_seq_pkg::status_t status;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000005d;
    int pc, vld, ph, gie, pend, ack, acc_m;
    logic [15:0] ir;
    logic [3:0] st_m;
    int stk[$];

    initial
    begin
        forever #2 clk = ~clk;
    end

    cpu_fetch_sequencer_stack #(.PC_HIGH_W(4), .STACK_DEPTH(DEPTH)) cpu_fetch_sequencer_stack_i (
        .clk(clk), .reset(reset), .ce(ce), .prog_addr(prog_addr), .prog_data(prog_data),
        .irq_req(irq_req), .irq_ack(irq_ack), .phase(phase), .dummy_cycle(dummy_cycle),
        .acc(acc), .status(status));

    prog_mem_model #(.AW(AW)) prog_mem_model_i (
        .clk(clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .irq_fire(irq_fire), .irq_req(irq_req));

    // ********************
    // Reference model
    // ********************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [7:0] alu(input int op, input logic [7:0] a, input logic [7:0] b);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] h;
        logic cin;
        bb = (op == 3 || op == 4) ? ~b : b;
        cin = (op == 2 || op == 4) ? st_m[0] : (op == 3);
        s = a + bb + cin;
        h = a[3:0] + bb[3:0] + cin;
        case (op)
            0: alu = b;
            1, 2, 3, 4: alu = s[7:0];
            5: alu = a & b;
            6: alu = a | b;
            7: alu = a ^ b;
            8: alu = ~a;
            9: alu = {a[0], a[7:1]};
            10: alu = {st_m[0], a[7:1]};
            11: alu = {a[6:0], a[7]};
            12: alu = {a[6:0], st_m[0]};
            13: alu = a + 8'h01;
            default: alu = a - 8'h01;
        endcase
        if (op >= 1 && op <= 4)
            st_m = {(a[7] == bb[7]) && (alu[7] != a[7]), st_m[2], h[4], s[8]};
        if (op == 10 || op == 12)
            st_m[0] = (op == 10) ? a[0] : a[7];
        if (op < 9 || op > 12)
            st_m[2] = (alu == 8'h00);
    endfunction : alu

    task automatic push(input int v);
        stk.push_back(v);
        if (stk.size() > DEPTH)
            void'(stk.pop_front());
    endtask : push

    task automatic cyc_end();
        int opc, npc, nd, br;
        logic [7:0] b;
        opc = ir[15:13];
        npc = pc + 1;
        nd = 0;
        br = 0;
        b = ir[12] ? pc[7:0] : ir[7:0];
        if (vld)
        begin
            br = (opc > 1 && opc < 7) || (opc == 7 && acc_m == 0);
            case (opc)
                1: acc_m = alu(ir[11:8], acc_m[7:0], b);
                2: npc = (pc & 32'h00000f00) | alu(ir[11:8], acc_m[7:0], b);
                3: npc = ir;
                4: push(pc);
                5, 6: npc = stk.pop_back();
                default: nd = (opc == 7) && (acc_m == 0);
            endcase
            if (opc == 4)
                npc = ir;
            if (opc == 6)
                gie = 1;
            nd = nd || (opc > 1 && opc < 7);
        end
        if (pend && gie && stk.size() < DEPTH && !br)
        begin
            push(pc);
            npc = cpu_seq_pkg::INT_VECTOR;
            nd = 1;
            gie = 0;
            pend = 0;
            ack = 1;
        end
        ir = prog_mem_model_i.rom[pc];
        pc = npc & 32'h00000fff;
        vld = !nd;
    endtask : cyc_end

    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pc = 0;
            vld = 0;
            ph = 0;
            gie = 1;
            pend = 0;
            ack = 0;
            acc_m = 0;
            st_m = 4'h0;
            stk.delete();
        end
        else if (ce)
        begin
            ack = 0;
            if (ph == 3)
                cyc_end();
            if (irq_req)
                pend = 1;
            ph = (ph + 1) % 4;
        end
    end

    // ********************
    // Checking
    // ********************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    always @(negedge clk)
    begin
        cycles++;
        if (cycles > TMO)
        begin
            num_errors++;
            test_done();
        end
        else if (!reset)
        begin
            chk(16'(prog_addr), 16'(pc));
            chk(16'(phase), 16'(1 << ph));
            chk(16'(dummy_cycle), 16'(!vld));
            chk(16'(acc), 16'(acc_m));
            chk(16'(status), 16'(st_m));
            chk(16'(irq_ack), 16'(ack));
        end
    end

    // ********************
    // Stimulus
    // ********************
    task automatic run(input int n, input int rnd_ce);
        repeat (n)
        begin
            @(posedge clk);
            ce <= rnd_ce ? (xs() % 4 != 0) : 1'b1;
        end
    endtask : run

    task automatic pulse_at(input int a);
        int n;
        n = 0;
        while (prog_addr !== AW'(a) && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 300)
            num_errors++;
        @(posedge clk);
        irq_fire <= 1'b1;
        @(posedge clk);
        irq_fire <= 1'b0;
    endtask : pulse_at

    initial
    begin
        logic [31:0] r;
        logic [2:0] o;
        // Random straight code, skips, page jumps, jumps and overflowing calls
        for (int i = 0; i < 4096; i++)
        begin
            r = xs();
            o = r[31:28] > 13 ? 3'h1 : r[31:28] < 9 ? 3'h1 : r[31:28] < 11 ? 3'h7 : 3'(r[31:28] - 9);
            prog_mem_model_i.rom[i] = (o == 3 || o == 4) ? {o, r[12:0]}
                : {o, r[12], 4'(r[27:24] % 15), r[7:0]};
        end
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        run(3000, 1);
        // Nested calls, overflow, held interrupt and handler
        @(posedge clk);
        reset <= 1'b1;
        ce <= 1'b1;
        for (int i = 0; i < 4096; i++)
            prog_mem_model_i.rom[i] = 16'h0000;
        prog_mem_model_i.rom[0] = 16'h800a;
        prog_mem_model_i.rom[10] = 16'h8014;
        prog_mem_model_i.rom[20] = 16'h801e;
        prog_mem_model_i.rom[33] = 16'ha000;
        prog_mem_model_i.rom[4] = 16'h205a;
        prog_mem_model_i.rom[6] = 16'hc000;
        prog_mem_model_i.rom[21] = 16'h2101;
        prog_mem_model_i.rom[22] = 16'ha000;
        prog_mem_model_i.rom[11] = 16'h600b;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        pulse_at(31);
        pulse_at(5);
        run(150, 0);
        test_done();
    end
endmodule : tb_cpu_fetch_sequencer_stack
